/* hw/csw_clock_control.sv */
// clock source switching, fail-safe fallback and sleep / idle control
// assumes all inputs synchronous to mclk_in; new_clk_tick_in pulses once per new clock cycle
`timescale 1ns/1ps
//
// Function
// [RULE1] switching and fail-safe monitor only when switch fuse is 0
// [RULE2] switching disabled: next field ignored, current shows reset fuse source
// [RULE3] switching disabled: request bit ignored and reads zero
// [RULE4] software unlocks each byte before writing, then sets request
// [RULE5] two key writes open one write; any other access closes it
// [RULE6] request with next equal to current clears request, no switch
// [RULE7] valid switch start clears lock and failure flags; lock stays set here if the running pll is locked
// [RULE8] enable new source; wait startup timer for crystal, lock for pll
// [RULE9] wait ten new-clock cycles before changing over
// [RULE10] on completion clear request and copy next into current
// [RULE11] old source off, except slow rc for watchdog/monitor, kept crystal
// [RULE12] software avoids direct pll-to-pll switches between primary and fast rc
// [RULE13] monitor enabled keeps slow rc running except in sleep
// [RULE14] monitored failure raises trap and falls back to fast rc
// [RULE15] fallback keeps pll when pll was in use
// [RULE16] sleep operand stops clocks; idle operand halts only the cpu
// [RULE17] sleep shuts sources, monitor and system-clocked peripherals
// [RULE18] watchdog cleared before sleep; slow rc runs in sleep if watchdog on
// [RULE19] wake on enabled interrupt, reset or watchdog time-out
// [RULE20] sleep wake resumes on the same source
// [RULE21] idle clears watchdog, keeps system clock and needed slow rc
// [RULE22] idle wake resumes the cpu two cycles later
// [RULE23] interrupt during power-save entry is held, then wakes at once
module csw_clock_control (
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic switch_enable_fuse_in,
   input wire logic [2:0] reset_source_fuse_in,
   input wire logic monitor_enable_fuse_in,
   input wire logic [1:0] primary_submode_fuse_in,
   input wire logic watchdog_enable_in,
   input wire logic low_power_crystal_keep_in,
   input wire logic key_wr_in,
   input wire logic byte_wr_in,
   input wire logic byte_high_in,
   input wire logic [7:0] wr_data_in,
   input wire logic startup_timer_done_in,
   input wire logic pll_lock_in,
   input wire logic new_clk_tick_in,
   input wire logic osc_fail_in,
   input wire logic power_save_instr_in,
   input wire logic power_save_sleep_in,
   input wire logic irq_in,
   input wire logic watchdog_timeout_in,
   output logic [15:0] osc_control_out,
   output logic [2:0] sys_clk_sel_out,
   output logic sys_clk_en_out,
   output logic periph_clk_en_out,
   output logic cpu_halt_out,
   output logic cpu_resume_out,
   output logic watchdog_clear_out,
   output logic clock_fail_trap_out,
   output logic fast_rc_en_out,
   output logic slow_rc_en_out,
   output logic primary_en_out,
   output logic low_power_crystal_en_out,
   output logic pll_en_out
);
   // ==========================================
   // state
   csw_pkg::csw_sw_state_type sw_reg, sw_next;
   csw_pkg::csw_pm_state_type pm_reg, pm_next;
   csw_pkg::csw_unlock_type ul_reg, ul_next;
   logic [2:0] cur_reg, cur_next;
   logic [2:0] next_reg, next_next;
   logic req_reg, req_next;
   logic cf_reg, cf_next;
   logic lock_reg, lock_next;
   logic [3:0] settle_reg, settle_next;
   logic [1:0] resume_reg, resume_next;
   logic trap_reg, trap_next;
   logic wdclr_reg, wdclr_next;
   logic resume_out_reg, resume_out_next;

   // ==========================================
   // decode
   wire sw_allow = !switch_enable_fuse_in; // [RULE1]
   wire fail_safe_monitor_en = sw_allow && monitor_enable_fuse_in; // [RULE1]
   wire sleeping = (pm_reg == csw_pkg::PM_SLEEP);
   wire fail_safe_monitor_active = fail_safe_monitor_en && !sleeping; // [RULE17]
   wire [2:0] cur_src = sw_allow ? cur_reg : reset_source_fuse_in; // [RULE2]
   wire busy = (sw_reg != csw_pkg::SW_IDLE);
   wire target_on = busy && (sw_reg != csw_pkg::SW_CHECK);
   wire next_crystal = (next_reg == csw_pkg::SRC_LP) ||
      (csw_pkg::is_pri(next_reg) && primary_submode_fuse_in != csw_pkg::SUBMODE_EC);
   wire ready = (!next_crystal || startup_timer_done_in) && // [RULE8]
      (!csw_pkg::is_pll(next_reg) || lock_reg); // [RULE8]
   wire fail_hit = fail_safe_monitor_active && osc_fail_in && !csw_pkg::is_frc(cur_src); // [RULE14]
   wire hi_write = byte_wr_in && byte_high_in && (ul_reg == csw_pkg::UL_HI_OPEN); // [RULE5]
   wire lo_write = byte_wr_in && !byte_high_in && (ul_reg == csw_pkg::UL_LO_OPEN); // [RULE5]
   wire req_set = sw_allow && lo_write && wr_data_in[csw_pkg::REQ_BIT]; // [RULE3]
   wire wake_evt = irq_in || watchdog_timeout_in; // [RULE19]
   wire frc_want = csw_pkg::is_frc(cur_src) || (target_on && csw_pkg::is_frc(next_reg));
   wire pri_want = csw_pkg::is_pri(cur_src) || (target_on && csw_pkg::is_pri(next_reg));
   wire pll_want = csw_pkg::is_pll(cur_src) || (target_on && csw_pkg::is_pll(next_reg));
   wire lp_src = (cur_src == csw_pkg::SRC_LP) ||
      (target_on && next_reg == csw_pkg::SRC_LP);
   wire slow_internal_rc_src = (cur_src == csw_pkg::SRC_SLOW_INTERNAL_RC) ||
      (target_on && next_reg == csw_pkg::SRC_SLOW_INTERNAL_RC);

   // ==========================================
   // unlock keys
   always_comb
   begin
      ul_next = csw_pkg::UL_NONE; // [RULE5]
      if (key_wr_in)
      begin
         if (wr_data_in == csw_pkg::KEY_HI_A)
            ul_next = csw_pkg::UL_HI1;
         else if (wr_data_in == csw_pkg::KEY_LO_A)
            ul_next = csw_pkg::UL_LO1;
         else if (ul_reg == csw_pkg::UL_HI1 && wr_data_in == csw_pkg::KEY_HI_B)
            ul_next = csw_pkg::UL_HI_OPEN;
         else if (ul_reg == csw_pkg::UL_LO1 && wr_data_in == csw_pkg::KEY_LO_B)
            ul_next = csw_pkg::UL_LO_OPEN;
      end
      else if (!byte_wr_in)
         ul_next = ul_reg;
   end

   // ==========================================
   // switch sequencer
   always_comb
   begin
      sw_next = sw_reg;
      cur_next = cur_reg;
      next_next = hi_write ? wr_data_in[2:0] : next_reg;
      req_next = req_reg || req_set;
      cf_next = cf_reg;
      lock_next = lock_reg || (pll_lock_in && pll_en_out);
      settle_next = settle_reg;
      trap_next = 1'b0;
      if (!sleeping)
      begin
         unique case (sw_reg)
            csw_pkg::SW_IDLE:
               if (req_reg)
                  sw_next = csw_pkg::SW_CHECK;
            csw_pkg::SW_CHECK:
               if (next_reg == cur_reg)
               begin
                  req_next = req_set; // [RULE6]
                  sw_next = csw_pkg::SW_IDLE;
               end
               else
               begin
                  cf_next = 1'b0; // [RULE7]
                  lock_next = pll_lock_in && pll_en_out; // [RULE7]
                  sw_next = csw_pkg::SW_WAIT;
               end
            csw_pkg::SW_WAIT:
               if (ready)
               begin
                  settle_next = 4'h0;
                  sw_next = csw_pkg::SW_COUNT;
               end
            csw_pkg::SW_COUNT:
            begin
               // ticks are counted in the new clock, not ours
               if (new_clk_tick_in)
                  settle_next = settle_reg + 4'h1; // [RULE9]
               if (new_clk_tick_in && settle_reg == csw_pkg::SETTLE_TICKS - 4'h1)
                  sw_next = csw_pkg::SW_DONE; // [RULE9]
            end
            csw_pkg::SW_DONE:
            begin
               cur_next = next_reg; // [RULE10]
               req_next = req_set; // [RULE10]
               sw_next = csw_pkg::SW_IDLE;
            end
            default:
               sw_next = csw_pkg::SW_IDLE;
         endcase
      end
      if (fail_hit)
      begin
         // failure aborts any switch in progress
         trap_next = 1'b1; // [RULE14]
         cf_next = 1'b1; // [RULE14]
         req_next = 1'b0;
         sw_next = csw_pkg::SW_IDLE;
         cur_next = csw_pkg::is_pll(cur_src) ? csw_pkg::SRC_FRC_PLL : csw_pkg::SRC_FRC; // [RULE15]
      end
      if (!sw_allow)
         req_next = 1'b0; // [RULE3]
   end

   // ==========================================
   // power modes
   always_comb
   begin
      pm_next = pm_reg;
      resume_next = resume_reg;
      wdclr_next = 1'b0;
      resume_out_next = 1'b0;
      unique case (pm_reg)
         csw_pkg::PM_RUN:
            if (power_save_instr_in)
            begin
               wdclr_next = watchdog_enable_in; // [RULE18]
               pm_next = csw_pkg::PM_ENTER; // [RULE16]
            end
         // wake events ignored here so entry always completes first
         csw_pkg::PM_ENTER:
            pm_next = power_save_sleep_in ? csw_pkg::PM_SLEEP : csw_pkg::PM_IDLE; // [RULE23]
         csw_pkg::PM_SLEEP,
         csw_pkg::PM_IDLE:
            if (wake_evt)
            begin
               resume_next = 2'h0;
               pm_next = csw_pkg::PM_WAKE; // [RULE19]
            end
         csw_pkg::PM_WAKE:
         begin
            resume_next = resume_reg + 2'h1; // [RULE22]
            if (resume_reg == csw_pkg::RESUME_CYCLES - 2'h1)
            begin
               resume_out_next = 1'b1;
               pm_next = csw_pkg::PM_RUN; // [RULE22]
            end
         end
         default:
            pm_next = csw_pkg::PM_RUN;
      endcase
   end

   // ==========================================
   // registers
   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
      begin
         sw_reg <= csw_pkg::SW_IDLE;
         pm_reg <= csw_pkg::PM_RUN; // [RULE19]
         ul_reg <= csw_pkg::UL_NONE;
         cur_reg <= reset_source_fuse_in;
         next_reg <= csw_pkg::NEXT_RESET;
         req_reg <= 1'b0;
         cf_reg <= 1'b0;
         lock_reg <= 1'b0;
         settle_reg <= 4'h0;
         resume_reg <= 2'h0;
         trap_reg <= 1'b0;
         wdclr_reg <= 1'b0;
         resume_out_reg <= 1'b0;
      end
      else
      begin
         sw_reg <= sw_next;
         pm_reg <= pm_next;
         ul_reg <= ul_next;
         cur_reg <= cur_next;
         next_reg <= next_next;
         req_reg <= req_next;
         cf_reg <= cf_next;
         lock_reg <= lock_next;
         settle_reg <= settle_next;
         resume_reg <= resume_next;
         trap_reg <= trap_next;
         wdclr_reg <= wdclr_next;
         resume_out_reg <= resume_out_next;
      end
   end

   // ==========================================
   // outputs
   assign osc_control_out = {1'b0, cur_src, 1'b0, next_reg, 2'h0, lock_reg, 1'b0,
      cf_reg, 2'h0, req_reg};
   assign sys_clk_sel_out = cur_src; // [RULE20]
   assign sys_clk_en_out = !sleeping; // [RULE17]
   assign periph_clk_en_out = !sleeping; // [RULE21]
   assign cpu_halt_out = (pm_reg != csw_pkg::PM_RUN); // [RULE16]
   assign cpu_resume_out = resume_out_reg;
   assign watchdog_clear_out = wdclr_reg;
   assign clock_fail_trap_out = trap_reg;
   assign fast_rc_en_out = !sleeping && frc_want; // [RULE11]
   assign primary_en_out = !sleeping && pri_want; // [RULE11]
   assign pll_en_out = !sleeping && pll_want; // [RULE17]
   // a kept crystal may run through sleep; it draws little and saves restart time
   assign low_power_crystal_en_out = low_power_crystal_keep_in || (!sleeping && lp_src); // [RULE11]
   assign slow_rc_en_out = watchdog_enable_in || fail_safe_monitor_active || (!sleeping && slow_internal_rc_src); // [RULE13]

   // ==========================================
   // checks
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (srst_in);
   property p_req_zero;
      !sw_allow |-> !osc_control_out[csw_pkg::REQ_BIT];
   endproperty
   a_req_zero: assert property (p_req_zero) else $error("request set while disabled"); // [RULE3]
   property p_cur_fuse;
      !sw_allow |-> (sys_clk_sel_out == reset_source_fuse_in);
   endproperty
   a_cur_fuse: assert property (p_cur_fuse) else $error("source not from fuse"); // [RULE2]
   property p_redundant;
      (sw_reg == csw_pkg::SW_CHECK && next_reg == cur_reg && !sleeping && !fail_hit)
         |=> (sw_reg == csw_pkg::SW_IDLE) && (req_reg == $past(req_set));
   endproperty
   a_redundant: assert property (p_redundant) else $error("redundant switch not aborted"); // [RULE6]
   property p_cf_clear;
      (sw_reg == csw_pkg::SW_CHECK && next_reg != cur_reg && !sleeping && !fail_hit)
         |=> !cf_reg;
   endproperty
   a_cf_clear: assert property (p_cf_clear) else $error("fail flag not cleared"); // [RULE7]
   property p_wait_lock;
      (sw_reg == csw_pkg::SW_WAIT && csw_pkg::is_pll(next_reg) && !lock_reg)
         |=> (sw_reg != csw_pkg::SW_COUNT);
   endproperty
   a_wait_lock: assert property (p_wait_lock) else $error("switched before lock"); // [RULE8]
   property p_settle;
      (sw_reg == csw_pkg::SW_DONE) |-> (settle_reg == csw_pkg::SETTLE_TICKS);
   endproperty
   a_settle: assert property (p_settle) else $error("settle count wrong"); // [RULE9]
   property p_done;
      (sw_reg == csw_pkg::SW_DONE && !sleeping && !fail_hit)
         |=> (cur_reg == $past(next_reg)) && (req_reg == $past(req_set));
   endproperty
   a_done: assert property (p_done) else $error("switch completion wrong"); // [RULE10]
   property p_fail;
      fail_hit |=> clock_fail_trap_out && csw_pkg::is_frc(cur_reg) ##1 !clock_fail_trap_out;
   endproperty
   a_fail: assert property (p_fail) else $error("fail fallback wrong"); // [RULE14]
   property p_sleep_off;
      sleeping |-> !sys_clk_en_out && !fast_rc_en_out && !primary_en_out && !pll_en_out;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("clock on in sleep"); // [RULE17]
   property p_resume;
      $rose(pm_reg == csw_pkg::PM_WAKE) |-> (pm_reg == csw_pkg::PM_WAKE) [*2]
         ##1 (pm_reg == csw_pkg::PM_RUN) && !cpu_halt_out;
   endproperty
   a_resume: assert property (p_resume) else $error("resume timing wrong"); // [RULE22]
   property p_enter;
      (pm_reg == csw_pkg::PM_ENTER) |=> (pm_reg == csw_pkg::PM_SLEEP) ||
         (pm_reg == csw_pkg::PM_IDLE);
   endproperty
   a_enter: assert property (p_enter) else $error("entry not completed"); // [RULE23]
   c_switch: cover property (sw_reg == csw_pkg::SW_DONE);
   c_redundant: cover property (sw_reg == csw_pkg::SW_CHECK && next_reg == cur_reg);
   c_fail: cover property (fail_hit);
   c_sleep_wake: cover property (sleeping ##1 pm_reg == csw_pkg::PM_WAKE);
endmodule

/* include/csw_pkg.sv */
// constants, types and helpers for the clock switch and power mode block
// assumes a single system clock; fuses are static levels
package csw_pkg;
   // ==========================================
   // clock source codes
   localparam logic [2:0] SRC_FRC = 3'h0;
   localparam logic [2:0] SRC_FRC_PLL = 3'h1;
   localparam logic [2:0] SRC_PRI = 3'h2;
   localparam logic [2:0] SRC_PRI_PLL = 3'h3;
   localparam logic [2:0] SRC_LP = 3'h4;
   localparam logic [2:0] SRC_SLOW_INTERNAL_RC = 3'h5;
   localparam logic [1:0] SUBMODE_EC = 2'h0;
   // ==========================================
   // unlock keys, values arbitrary
   localparam logic [7:0] KEY_HI_A = 8'h3c;
   localparam logic [7:0] KEY_HI_B = 8'hc3;
   localparam logic [7:0] KEY_LO_A = 8'h69;
   localparam logic [7:0] KEY_LO_B = 8'h96;
   // ==========================================
   // control word field positions and reset values
   localparam int REQ_BIT = 0;
   localparam int CF_BIT = 3;
   localparam int LOCK_BIT = 5;
   localparam int NEXT_LSB = 8;
   localparam int CUR_LSB = 12;
   localparam logic [2:0] NEXT_RESET = 3'h0;
   // ==========================================
   // counts
   localparam logic [3:0] SETTLE_TICKS = 4'ha;
   localparam logic [1:0] RESUME_CYCLES = 2'h2;
   // ==========================================
   // state types
   typedef enum logic [2:0] {SW_IDLE = 3'h0, SW_CHECK = 3'h1, SW_WAIT = 3'h3,
      SW_COUNT = 3'h2, SW_DONE = 3'h6} csw_sw_state_type;
   typedef enum logic [2:0] {PM_RUN = 3'h0, PM_ENTER = 3'h1, PM_SLEEP = 3'h3,
      PM_IDLE = 3'h2, PM_WAKE = 3'h6} csw_pm_state_type;
   typedef enum logic [2:0] {UL_NONE = 3'h0, UL_HI1 = 3'h1, UL_HI_OPEN = 3'h3,
      UL_LO1 = 3'h2, UL_LO_OPEN = 3'h6} csw_unlock_type;
   // ==========================================
   // source helpers
   function automatic logic is_pll(input logic [2:0] s);
      return (s == SRC_FRC_PLL) || (s == SRC_PRI_PLL);
   endfunction
   function automatic logic is_frc(input logic [2:0] s);
      return (s == SRC_FRC) || (s == SRC_FRC_PLL);
   endfunction
   function automatic logic is_pri(input logic [2:0] s);
      return (s == SRC_PRI) || (s == SRC_PRI_PLL);
   endfunction
endpackage

/* test/csw_osc_model.sv */
// oscillator side model: crystal start-up timer, pll lock, new-clock tick
// assumes enables from the clock control block, same system clock
`timescale 1ns/1ps
module csw_osc_model (
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic crystal_en_in,
   input wire logic pll_en_in,
   output logic startup_timer_done_out,
   output logic pll_lock_out,
   output logic new_clk_tick_out
);
   // ==========================================
   // start-up and lock delays
   // pll delay always longer than crystal start, so lock is the last event
   int xtal_cnt = 0;
   int pll_cnt = 0;
   int xtal_dly = 4;
   int pll_dly = 20;
   always @(posedge mclk_in)
   begin
      if (srst_in)
      begin
         xtal_cnt <= 0;
         pll_cnt <= 0;
         new_clk_tick_out <= 1'b0;
      end
      else
      begin
         // new clock at half rate, so ticks come every other cycle
         new_clk_tick_out <= ~new_clk_tick_out;
         if (!crystal_en_in)
         begin
            xtal_cnt <= 0;
            xtal_dly <= 4 + ($urandom % 12);
         end
         else if (xtal_cnt < xtal_dly)
            xtal_cnt <= xtal_cnt + 1;
         if (!pll_en_in)
         begin
            pll_cnt <= 0;
            pll_dly <= 20 + ($urandom % 12);
         end
         else if (pll_cnt < pll_dly)
            pll_cnt <= pll_cnt + 1;
      end
   end
   // flags drop as soon as the source is switched off
   assign startup_timer_done_out = crystal_en_in && (xtal_cnt >= xtal_dly);
   assign pll_lock_out = pll_en_in && (pll_cnt >= pll_dly);
endmodule

/* test/tb.sv */
// self-checking bench for the clock switch and power mode block
// assumes the oscillator model on the far side and static fuse levels per run
`timescale 1ns/1ps
module tb;
   // ==========================================
   // signals
   logic mclk_in = 1'b0;
   logic srst_in = 1'b1;
   logic switch_enable_fuse_in = 1'b1;
   logic [2:0] reset_source_fuse_in = 3'h0;
   logic monitor_enable_fuse_in = 1'b0;
   logic [1:0] primary_submode_fuse_in = 2'h1;
   logic watchdog_enable_in = 1'b0;
   logic low_power_crystal_keep_in = 1'b0;
   logic key_wr_in = 1'b0;
   logic byte_wr_in = 1'b0;
   logic byte_high_in = 1'b0;
   logic [7:0] wr_data_in = 8'h00;
   logic osc_fail_in = 1'b0;
   logic power_save_instr_in = 1'b0;
   logic power_save_sleep_in = 1'b0;
   logic irq_in = 1'b0;
   logic watchdog_timeout_in = 1'b0;
   logic startup_timer_done, pll_lock, new_clk_tick;
   logic [15:0] osc_control_out;
   logic [2:0] sys_clk_sel_out;
   logic sys_clk_en_out, periph_clk_en_out, cpu_halt_out, cpu_resume_out;
   logic watchdog_clear_out, clock_fail_trap_out, fast_rc_en_out, slow_rc_en_out;
   logic primary_en_out, low_power_crystal_en_out, pll_en_out;
   int failures = 0;
   int num_checks = 0;
   logic [3:0] notes[$];
   logic [2:0] exp_src;
   logic lp_seen = 1'b0;
   always #12.5 mclk_in = ~mclk_in;
   // ==========================================
   // instances
   csw_clock_control i_dut (.mclk_in(mclk_in), .srst_in(srst_in),
      .switch_enable_fuse_in(switch_enable_fuse_in), .reset_source_fuse_in(reset_source_fuse_in),
      .monitor_enable_fuse_in(monitor_enable_fuse_in),
      .primary_submode_fuse_in(primary_submode_fuse_in), .watchdog_enable_in(watchdog_enable_in),
      .low_power_crystal_keep_in(low_power_crystal_keep_in), .key_wr_in(key_wr_in),
      .byte_wr_in(byte_wr_in), .byte_high_in(byte_high_in), .wr_data_in(wr_data_in),
      .startup_timer_done_in(startup_timer_done), .pll_lock_in(pll_lock),
      .new_clk_tick_in(new_clk_tick), .osc_fail_in(osc_fail_in),
      .power_save_instr_in(power_save_instr_in), .power_save_sleep_in(power_save_sleep_in),
      .irq_in(irq_in), .watchdog_timeout_in(watchdog_timeout_in),
      .osc_control_out(osc_control_out), .sys_clk_sel_out(sys_clk_sel_out),
      .sys_clk_en_out(sys_clk_en_out), .periph_clk_en_out(periph_clk_en_out),
      .cpu_halt_out(cpu_halt_out), .cpu_resume_out(cpu_resume_out),
      .watchdog_clear_out(watchdog_clear_out), .clock_fail_trap_out(clock_fail_trap_out),
      .fast_rc_en_out(fast_rc_en_out), .slow_rc_en_out(slow_rc_en_out),
      .primary_en_out(primary_en_out), .low_power_crystal_en_out(low_power_crystal_en_out),
      .pll_en_out(pll_en_out));
   csw_osc_model i_osc (.mclk_in(mclk_in), .srst_in(srst_in),
      .crystal_en_in(primary_en_out | low_power_crystal_en_out), .pll_en_in(pll_en_out),
      .startup_timer_done_out(startup_timer_done), .pll_lock_out(pll_lock),
      .new_clk_tick_out(new_clk_tick));
   // ==========================================
   // compare and closing tasks
   task automatic check_src(input string name, input logic [2:0] exp, input logic [2:0] got);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic check_bit(input string name, input logic exp, input logic got);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %s expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic summarize();
      if (failures == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ==========================================
   // result watcher: switch done, trap, cpu resume
   logic req_q = 1'b0;
   logic tdone_q = 1'b0;
   logic lock_q = 1'b0;
   logic [3:0] note;
   int tcnt = 0;
   always @(posedge mclk_in)
   begin
      if ((req_q === 1'b1 && osc_control_out[0] === 1'b0) || clock_fail_trap_out === 1'b1 ||
         cpu_resume_out === 1'b1)
      begin
         if (notes.size() == 0)
            check_bit("note_queue", 1'b1, 1'b0);
         else
         begin
            note = notes.pop_front();
            check_src("current_source", note[2:0], osc_control_out[14:12]);
            check_src("sys_clk_sel", note[2:0], sys_clk_sel_out);
            if (note[3])
               check_bit("settle_ticks", 1'b1, (tcnt >= 10) && (tcnt <= 13));
            if (clock_fail_trap_out === 1'b1)
               check_bit("clock_fail_flag", 1'b1, osc_control_out[3]);
         end
      end
      // ticks counted from the last readiness event of the new source
      if ((osc_control_out[0] && !req_q) || (startup_timer_done && !tdone_q) ||
         (pll_lock && !lock_q))
         tcnt = 0;
      else if (new_clk_tick)
         tcnt++;
      req_q = osc_control_out[0];
      tdone_q = startup_timer_done;
      lock_q = pll_lock;
   end
   // ==========================================
   // drivers
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   task automatic do_reset(input logic fuse, input logic [2:0] src, input logic mon);
      @(posedge mclk_in);
      srst_in <= 1'b1;
      switch_enable_fuse_in <= fuse;
      reset_source_fuse_in <= src;
      monitor_enable_fuse_in <= mon;
      tick(5);
      srst_in <= 1'b0;
      exp_src = src;
   endtask
   task automatic access(input logic is_key, input logic hi, input logic [7:0] data);
      @(posedge mclk_in);
      key_wr_in <= is_key;
      byte_wr_in <= !is_key;
      byte_high_in <= hi;
      wr_data_in <= data;
      @(posedge mclk_in);
      key_wr_in <= 1'b0;
      byte_wr_in <= 1'b0;
   endtask
   task automatic unlock_write(input logic hi, input logic [7:0] data);
      access(1'b1, hi, hi ? csw_pkg::KEY_HI_A : csw_pkg::KEY_LO_A);
      access(1'b1, hi, hi ? csw_pkg::KEY_HI_B : csw_pkg::KEY_LO_B);
      access(1'b0, hi, data);
   endtask
   task automatic switch_to(input logic [2:0] src, input logic full);
      int i;
      notes.push_back({full, src});
      unlock_write(1'b1, {5'h00, src});
      unlock_write(1'b0, 8'h01);
      tick(3);
      if (full)
         check_bit("clock_fail_flag", 1'b0, osc_control_out[3]);
      // lock can only read clear when the old source ran without the pll
      if (full && exp_src != csw_pkg::SRC_FRC_PLL && exp_src != csw_pkg::SRC_PRI_PLL)
         check_bit("lock_flag", 1'b0, osc_control_out[5]);
      for (i = 0; i < 3000; i++)
      begin
         if (osc_control_out[0] === 1'b0)
            break;
         @(posedge mclk_in);
      end
      exp_src = src;
      lp_seen = lp_seen | (src == csw_pkg::SRC_LP);
      // keep bit raised once the crystal runs, so later switches must leave it on
      if (src == csw_pkg::SRC_LP)
         low_power_crystal_keep_in <= 1'b1;
      tick(2);
      check_bit("pll_en", src == csw_pkg::SRC_FRC_PLL || src == csw_pkg::SRC_PRI_PLL, pll_en_out);
      check_bit("fast_rc_en", src <= csw_pkg::SRC_FRC_PLL, fast_rc_en_out);
      check_bit("lp_crystal_en", lp_seen, low_power_crystal_en_out);
   endtask
   task automatic power_save(input logic slp, input logic early, input logic by_wdt);
      int i;
      notes.push_back({1'b0, exp_src});
      @(posedge mclk_in);
      power_save_instr_in <= 1'b1;
      power_save_sleep_in <= slp;
      irq_in <= early;
      @(posedge mclk_in);
      power_save_instr_in <= 1'b0;
      @(posedge mclk_in);
      check_bit("cpu_halt", 1'b1, cpu_halt_out);
      check_bit("watchdog_clear", 1'b1, watchdog_clear_out);
      if (!early)
      begin
         tick(2);
         check_bit("sys_clk_en", !slp, sys_clk_en_out);
         check_bit("periph_clk_en", !slp, periph_clk_en_out);
         check_bit("slow_rc_en", 1'b1, slow_rc_en_out);
         if (slp)
            check_bit("primary_en", 1'b0, primary_en_out);
         watchdog_timeout_in <= by_wdt;
         irq_in <= !by_wdt;
      end
      for (i = 0; i < 12; i++)
      begin
         @(posedge mclk_in);
         if (cpu_resume_out === 1'b1)
            break;
      end
      check_bit("resume_delay", 1'b1, i >= 2 && i <= 4);
      irq_in <= 1'b0;
      watchdog_timeout_in <= 1'b0;
      tick(2);
   endtask
   // ==========================================
   // main sequence
   // no direct pll-to-pll hop between primary and fast rc in this order
   logic [2:0] order [5] = '{csw_pkg::SRC_FRC_PLL, csw_pkg::SRC_PRI, csw_pkg::SRC_LP,
      csw_pkg::SRC_SLOW_INTERNAL_RC, csw_pkg::SRC_PRI_PLL};
   logic [7:0] r;
   initial
   begin
      void'($urandom(15));
      tick(5);
      srst_in <= 1'b0;
      do_reset(1'b1, csw_pkg::SRC_PRI, 1'b1);
      unlock_write(1'b1, 8'h01);
      unlock_write(1'b0, 8'h01);
      tick(4);
      check_bit("switch_request", 1'b0, osc_control_out[0]);
      check_src("current_source", csw_pkg::SRC_PRI, osc_control_out[14:12]);
      check_src("sys_clk_sel", csw_pkg::SRC_PRI, sys_clk_sel_out);
      check_bit("slow_rc_en", 1'b0, slow_rc_en_out);
      do_reset(1'b0, csw_pkg::SRC_FRC, 1'b1);
      tick(1);
      check_bit("slow_rc_en", 1'b1, slow_rc_en_out);
      r = 8'($urandom);
      if (r == csw_pkg::KEY_HI_B)
         r = 8'h00;
      access(1'b1, 1'b1, csw_pkg::KEY_HI_A);
      access(1'b1, 1'b1, r);
      access(1'b0, 1'b1, 8'h04);
      unlock_write(1'b1, 8'h02);
      access(1'b0, 1'b1, 8'h05);
      tick(1);
      check_src("next_source_sel", 3'h2, osc_control_out[10:8]);
      switch_to(csw_pkg::SRC_FRC, 1'b0);
      foreach (order[k])
         switch_to(order[k], 1'b1);
      notes.push_back({1'b0, csw_pkg::SRC_FRC_PLL});
      @(posedge mclk_in);
      osc_fail_in <= 1'b1;
      @(posedge mclk_in);
      osc_fail_in <= 1'b0;
      exp_src = csw_pkg::SRC_FRC_PLL;
      tick(4);
      switch_to(csw_pkg::SRC_PRI, 1'b1);
      watchdog_enable_in <= 1'b1;
      power_save(1'b1, 1'b0, 1'b1);
      power_save(1'b0, 1'b0, 1'b0);
      power_save(1'b0, 1'b1, 1'b0);
      power_save(1'b1, 1'b1, 1'b0);
      check_bit("notes_drained", 1'b1, notes.size() == 0);
      summarize();
   end
   initial
   begin
      repeat (40000) @(posedge mclk_in);
      failures++;
      summarize();
   end
endmodule
